/* File: common/timer_pkg.sv */
// Shared constants, types and register map of the preset timer block.
// Assumes a single 250 MHz system clock; all rates come from enable pulses.
package timer_pkg;

    // ==================================================================
    // Timing
    // ==================================================================
    localparam int CLK_MHZ = 250;
    localparam int TICK_MS = 1;                              // Base tick period, ms
    localparam int MS_CYCLES_DEF = CLK_MHZ * 1000 * TICK_MS; // Cycles per base tick
    localparam int DEBOUNCE_US = 500;                        // Input settle time, us
    localparam int DEB_CYCLES_DEF = CLK_MHZ * DEBOUNCE_US;   // Cycles an input must hold
    localparam int TICK_CNT_W = 20;
    // Time base periods in base ticks, one per time range
    localparam logic [9:0] RANGE_SEC_FINE = 10'h001;    // 0.001 s
    localparam logic [9:0] RANGE_SEC_COARSE = 10'h00A;  // 0.01 s
    localparam logic [9:0] RANGE_MIN_FINE = 10'h03C;    // 0.001 min
    localparam logic [9:0] RANGE_MIN_COARSE = 10'h258;  // 0.01 min
    localparam logic [9:0] OUT_TICK_MS = 10'h00A;       // Timed output unit, 0.01 s

    // ==================================================================
    // Value ranges
    // ==================================================================
    localparam int COUNT_W = 20;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 20'hF423F;  // 999999 display counts
    localparam int DUR_W = 14;
    localparam logic [DUR_W-1:0] DUR_MIN = 14'h0001;       // 0.01 s
    localparam logic [DUR_W-1:0] DUR_MAX = 14'h270F;       // 99.99 s
    localparam logic [1:0] DP_FINE = 2'h3;
    localparam logic [1:0] DP_COARSE = 2'h2;

    // ==================================================================
    // Register port
    // ==================================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_PRESET1 = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PRESET2 = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DUR1 = 8'h08;
    localparam logic [ADDR_W-1:0] REG_DUR2 = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_COUNT = 8'h14;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h18;
    // Status fields
    localparam int ST_OUT1 = 0;
    localparam int ST_OUT2 = 1;
    localparam int ST_RUN = 2;
    localparam int ST_LOCK = 3;
    localparam int ST_ERR = 4;
    localparam int ST_HELD = 5;
    // Control fields
    localparam int CTRL_OUT_TEST = 0;

    // ==================================================================
    // Nonvolatile store
    // ==================================================================
    localparam int NV_AW = 2;
    localparam int NV_W = 20;
    localparam logic [NV_AW-1:0] NV_PRESET1 = 2'h0;
    localparam logic [NV_AW-1:0] NV_PRESET2 = 2'h1;
    localparam logic [NV_AW-1:0] NV_DUR1 = 2'h2;
    localparam logic [NV_AW-1:0] NV_DUR2 = 2'h3;
    localparam logic [2:0] LOAD_LAST = 3'h4;

    // ==================================================================
    // Mode switch fields and types
    // ==================================================================
    localparam int MODE_DOWN_BIT = 3;
    localparam int MODE_HOLD_BIT = 2;
    localparam int CTL_N = 5;

    typedef enum logic [1:0] {BHV_LATCH, BHV_TIMED, BHV_AUTO, BHV_HANDOFF} behaviour_t;
    typedef enum {ST_LOAD, ST_RUNNING} state_t;

    // Active-low control pins, one bit each
    typedef struct packed {
        logic enter;
        logic panel_btn;
        logic edit_lock;
        logic remote_rst;
        logic run;
    } ctl_in_t;

endpackage : timer_pkg

/* File: rtl/nv_settings_store.sv */
// Small retained store for presets and output durations.
// Assumes contents survive rstn; each word is kept with its complement so a
// damaged or blank entry can be told apart at power-up.
`timescale 1ns/1ps
module nv_settings_store
    import timer_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Write side
    input wire logic wr_en,
    input wire logic [NV_AW-1:0] wr_addr,
    input wire logic [NV_W-1:0] wr_data,
    // Read side
    input wire logic [NV_AW-1:0] rd_addr,
    output logic [NV_W-1:0] rd_data,
    output logic rd_bad
);

    // ==================================================================
    // Storage
    // ==================================================================
    logic [2*NV_W-1:0] mem [2**NV_AW];
    logic [2*NV_W-1:0] rd_word;

    // Blank store reads as damaged, like an unprogrammed device
    initial begin
        for (int i = 0; i < 2**NV_AW; i++) begin
            mem[i] = '0;
        end
    end

    // Write keeps data and complement together; read is registered
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= {~wr_data, wr_data};
        end
        rd_word <= mem[rd_addr];
    end

    assign rd_data = rd_word[NV_W-1:0];
    assign rd_bad = (rd_word[2*NV_W-1:NV_W] != ~rd_word[NV_W-1:0]);

endmodule : nv_settings_store

/* File: rtl/preset_timer.sv */
// Single or dual preset timer core with retained settings and register port.
// Assumes switch and control pins are slow contacts, asynchronous to clk_sys.
//
// Behaviour
// - Up from zero or down from preset
// - Eight modes single, sixteen modes dual
// - Mode from four rear switches
// - Resolution switch picks two or three decimals
// - Unit switch picks seconds or minutes
// - Rear switch can disable panel reset
// - Run input change seen within 1 ms
// - Remote reset low resets time and clears channel outputs
// - Edit lock refuses edits and output test
// - Manual reset overrides counting and channel outputs but not output test drive, restarts cycle
// - Each preset drives solid-state and relay
// - Timed output from 0.01 to 99.99 s
// - Retrigger during timed output keeps it on
// - Settings retained and restored after power loss
// - Self-test adds to output drive, never disturbs timing
// - Held in reset while remote stays low
// - Time accumulates only while run low
// - Stored-data error shown, cleared by enter
`timescale 1ns/1ps
module preset_timer
    import timer_pkg::*;
#(
    parameter bit DUAL_PRESET = 1'b1,
    parameter int MS_CYCLES = MS_CYCLES_DEF,
    parameter int DEB_CYCLES = DEB_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    // Rear switches
    input wire logic [3:0] mode_select_switches,
    input wire logic resolution_switch,
    input wire logic time_unit_switch,
    input wire logic panel_reset_switch,
    // Active-low control pins
    input wire logic run_in_n,
    input wire logic remote_reset_in_n,
    input wire logic edit_lock_in_n,
    input wire logic panel_reset_btn_n,
    input wire logic enter_key_n,
    // Loads and display
    output logic [1:0] ss_out,
    output logic [1:0] relay_out,
    output logic [COUNT_W-1:0] time_value,
    output logic [1:0] display_decimals,
    output logic data_error
);

    // ==================================================================
    // Input synchronisers and debouncers
    // ==================================================================
    logic [6:0] sw_meta;
    logic [6:0] sw_sync;
    logic [CTL_N-1:0] ctl_meta;
    logic [CTL_N-1:0] ctl_sync;
    logic [CTL_N-1:0] ctl_db;
    logic [TICK_CNT_W-1:0] deb_cnt [CTL_N];
    ctl_in_t ctl_raw;
    ctl_in_t act;
    logic panel_prev;
    logic enter_prev;

    assign ctl_raw = '{enter: enter_key_n, panel_btn: panel_reset_btn_n, edit_lock: edit_lock_in_n,
                       remote_rst: remote_reset_in_n, run: run_in_n};

    // Rear switches are static, two flops suffice
    always_ff @(posedge clk_sys) begin
        sw_meta <= {panel_reset_switch, time_unit_switch, resolution_switch, mode_select_switches};
        sw_sync <= sw_meta;
    end

    // Settle time is short of 1 ms so run changes still land in time
    for (genvar i = 0; i < CTL_N; i++) begin : g_deb
        always_ff @(posedge clk_sys) begin
            ctl_meta[i] <= ctl_raw[i];
            ctl_sync[i] <= ctl_meta[i];
            if (!rstn) begin
                deb_cnt[i] <= '0;
                ctl_db[i] <= 1'b1;
            end else if (ctl_sync[i] == ctl_db[i]) begin
                deb_cnt[i] <= '0;
            end else if (deb_cnt[i] == TICK_CNT_W'(DEB_CYCLES - 1)) begin
                deb_cnt[i] <= '0;
                ctl_db[i] <= ctl_sync[i];
            end else begin
                deb_cnt[i] <= deb_cnt[i] + 1'b1;
            end
        end
    end

    assign act = ctl_in_t'(~ctl_db);

    // Edge memory so one press gives one event
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            panel_prev <= 1'b0;
            enter_prev <= 1'b0;
        end else begin
            panel_prev <= act.panel_btn;
            enter_prev <= act.enter;
        end
    end

    // ==================================================================
    // Switch decode and manual reset
    // ==================================================================
    wire sw_fine = sw_sync[4];
    wire sw_minutes = sw_sync[5];
    wire panel_en = ~sw_sync[6];
    wire mode_down = sw_sync[MODE_DOWN_BIT];
    wire mode_hold = DUAL_PRESET & sw_sync[MODE_HOLD_BIT];
    behaviour_t bhv;
    assign bhv = behaviour_t'(sw_sync[1:0]);
    wire timed = (bhv == BHV_TIMED) || (bhv == BHV_AUTO);
    wire panel_press = act.panel_btn & ~panel_prev;
    wire enter_press = act.enter & ~enter_prev;
    wire manual_rst = act.remote_rst | (panel_press & panel_en);

    // ==================================================================
    // Time bases
    // ==================================================================
    logic [TICK_CNT_W-1:0] ms_cnt;
    logic [9:0] tb_cnt;
    logic [9:0] od_cnt;
    logic [9:0] range_ticks;

    assign range_ticks = sw_minutes ? (sw_fine ? RANGE_MIN_FINE : RANGE_MIN_COARSE)
                                    : (sw_fine ? RANGE_SEC_FINE : RANGE_SEC_COARSE);
    wire ms_tick = (ms_cnt == TICK_CNT_W'(MS_CYCLES - 1));
    wire tb_tick = ms_tick && (tb_cnt >= range_ticks - 10'h001);
    wire out_tick = ms_tick && (od_cnt == OUT_TICK_MS - 10'h001);

    // Time base restarts on manual reset; the ms prescaler runs on, so the first step can fall short of a full period
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ms_cnt <= '0;
            tb_cnt <= '0;
            od_cnt <= '0;
        end else begin
            ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
            if (manual_rst || tb_tick) begin
                tb_cnt <= '0;
            end else if (ms_tick) begin
                tb_cnt <= tb_cnt + 10'h001;
            end
            if (ms_tick) begin
                od_cnt <= out_tick ? '0 : od_cnt + 10'h001;
            end
        end
    end

    // ==================================================================
    // Settings, retained store and power-up check
    // ==================================================================
    state_t state;
    logic [2:0] load_idx;
    logic [COUNT_W-1:0] preset1;
    logic [COUNT_W-1:0] preset2;
    logic [DUR_W-1:0] dur [2];
    logic out_test;
    logic err;
    logic [NV_W-1:0] nv_rd_data;
    logic nv_rd_bad;

    wire running_state = (state == ST_RUNNING);
    wire load_cap = (state == ST_LOAD) && (load_idx != 3'h0);
    wire load_done = (state == ST_LOAD) && (load_idx == LOAD_LAST);
    wire [NV_AW-1:0] cap_idx = NV_AW'(load_idx - 3'h1);
    wire sel_p1 = (addr == REG_PRESET1);
    wire sel_p2 = (addr == REG_PRESET2);
    wire sel_d1 = (addr == REG_DUR1);
    wire sel_d2 = (addr == REG_DUR2);
    wire preset_ok = (wdata[DATA_W-1:COUNT_W] == '0) && (wdata[COUNT_W-1:0] <= COUNT_MAX);
    wire dur_ok = (wdata[DATA_W-1:DUR_W] == '0) && (wdata[DUR_W-1:0] >= DUR_MIN) && (wdata[DUR_W-1:0] <= DUR_MAX);
    wire edit_ok = wr_en && running_state && !act.edit_lock;
    wire nv_we = edit_ok && (((sel_p1 || sel_p2) && preset_ok) || ((sel_d1 || sel_d2) && dur_ok));
    wire [NV_AW-1:0] nv_wr_addr = sel_p1 ? NV_PRESET1 : sel_p2 ? NV_PRESET2 : sel_d1 ? NV_DUR1 : NV_DUR2;

    nv_settings_store u_store (
        .clk_sys(clk_sys),
        .wr_en(nv_we),
        .wr_addr(nv_wr_addr),
        .wr_data(wdata[NV_W-1:0]),
        .rd_addr(load_idx[NV_AW-1:0]),
        .rd_data(nv_rd_data),
        .rd_bad(nv_rd_bad)
    );

    // Load walks the store once after reset, then accepts edits
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= ST_LOAD;
            load_idx <= '0;
        end else if (load_done) begin
            state <= ST_RUNNING;
        end else if (state == ST_LOAD) begin
            load_idx <= load_idx + 3'h1;
        end
    end

    // Shadow copies: restored from the store, then tracked on every edit
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            preset1 <= '0;
            preset2 <= '0;
            dur[0] <= DUR_MIN;
            dur[1] <= DUR_MIN;
        end else if (load_cap) begin
            unique case (cap_idx)
                NV_PRESET1: preset1 <= nv_rd_data[COUNT_W-1:0];
                NV_PRESET2: preset2 <= nv_rd_data[COUNT_W-1:0];
                NV_DUR1: dur[0] <= nv_rd_data[DUR_W-1:0];
                NV_DUR2: dur[1] <= nv_rd_data[DUR_W-1:0];
            endcase
        end else if (nv_we) begin
            if (sel_p1) preset1 <= wdata[COUNT_W-1:0];
            if (sel_p2) preset2 <= wdata[COUNT_W-1:0];
            if (sel_d1) dur[0] <= wdata[DUR_W-1:0];
            if (sel_d2) dur[1] <= wdata[DUR_W-1:0];
        end
    end

    // Error set during load only, so a clear can never race it
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            err <= 1'b0;
            out_test <= 1'b0;
        end else begin
            if (load_cap && nv_rd_bad) begin
                err <= 1'b1;
            end else if (enter_press && running_state) begin
                err <= 1'b0;
            end
            if (wr_en && addr == REG_CTRL) begin
                out_test <= wdata[CTRL_OUT_TEST];
            end
        end
    end

    // ==================================================================
    // Time accumulation and preset compare
    // ==================================================================
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic [1:0] on;
    logic [1:0] hit;
    logic [1:0] end_evt;
    logic [DUR_W-1:0] otmr [2];

    wire [COUNT_W-1:0] start_val = DUAL_PRESET ? preset2 : preset1;
    wire [COUNT_W-1:0] reset_val = mode_down ? start_val : '0;
    wire [COUNT_W-1:0] final_tgt = mode_down ? '0 : start_val;
    wire [COUNT_W-1:0] first_tgt = DUAL_PRESET ? preset1 : final_tgt;
    wire at_end = mode_down ? (count == '0) : (count == COUNT_MAX);
    wire auto_rst = (bhv == BHV_AUTO) && end_evt[DUAL_PRESET ? 1 : 0];
    wire step = tb_tick && act.run && running_state && !at_end && !(mode_hold && count == final_tgt);
    wire restart = manual_rst || auto_rst || load_done;

    assign next_count = restart ? reset_val : step ? (mode_down ? count - 1'b1 : count + 1'b1) : count;
    assign hit[0] = step && (next_count == first_tgt) && !restart;
    assign hit[1] = DUAL_PRESET && step && (next_count == final_tgt) && !restart;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // ==================================================================
    // Output channels, one per preset
    // ==================================================================
    for (genvar c = 0; c < 2; c++) begin : g_chan
        assign end_evt[c] = timed && out_tick && on[c] && (otmr[c] == DUR_MIN) && !hit[c];
        always_ff @(posedge clk_sys) begin
            if (!rstn || manual_rst) begin
                on[c] <= 1'b0;
                otmr[c] <= '0;
            end else if (hit[c]) begin
                on[c] <= 1'b1;
                otmr[c] <= dur[c];
            end else if (end_evt[c]) begin
                on[c] <= 1'b0;
                otmr[c] <= '0;
            end else if (c == 0 && bhv == BHV_HANDOFF && hit[1]) begin
                on[c] <= 1'b0;
            end else if (timed && out_tick && on[c]) begin
                otmr[c] <= otmr[c] - DUR_MIN;
            end
        end
    end

    // Test drive only adds to the real outputs, timing never pauses
    wire [1:0] drive = on | {2{out_test & ~act.edit_lock}};

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ss_out <= '0;
            relay_out <= '0;
            display_decimals <= DP_COARSE;
        end else begin
            ss_out <= drive;
            relay_out <= drive;
            display_decimals <= sw_fine ? DP_FINE : DP_COARSE;
        end
    end

    assign time_value = count;
    assign data_error = err;

    // ==================================================================
    // Register read-back
    // ==================================================================
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_mux;

    assign status_word = DATA_W'({act.remote_rst, err, act.edit_lock, step | (act.run & running_state), on});
    assign rd_mux = sel_p1 ? DATA_W'(preset1) : sel_p2 ? DATA_W'(preset2) : sel_d1 ? DATA_W'(dur[0])
                  : sel_d2 ? DATA_W'(dur[1]) : (addr == REG_STATUS) ? status_word
                  : (addr == REG_COUNT) ? DATA_W'(count) : (addr == REG_CTRL) ? DATA_W'(out_test) : '0;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= rd_en ? rd_mux : '0;
        end
    end

    // ==================================================================
    // Assertions
    // ==================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence remote_held;
        act.remote_rst [*2];
    endsequence

    up_step_a: assert property (step && !mode_down && !restart |=> count == $past(count) + 1'b1)
        else $error("count did not step up");
    remote_clear_a: assert property (act.remote_rst |=> count == $past(reset_val) && on == 2'b00)
        else $error("remote reset did not clear");
    remote_hold_a: assert property (remote_held |-> ##1 (count == $past(reset_val)))
        else $error("time moved under held reset");
    run_gate_a: assert property (!act.run && !restart |=> $stable(count))
        else $error("time moved while stopped");
    panel_gate_a: assert property (manual_rst |-> act.remote_rst || panel_en)
        else $error("disabled panel reset acted");
    edit_lock_a: assert property (wr_en && act.edit_lock |=> $stable(preset1) && $stable(preset2))
        else $error("edit accepted while locked");
    pair_out_a: assert property (ss_out == relay_out)
        else $error("output pair differs");
    match_on_a: assert property (hit[0] && !manual_rst |=> on[0] ##1 ss_out[0])
        else $error("preset match lost");
    timed_off_a: assert property (end_evt[0] && !manual_rst |=> !on[0])
        else $error("timed output stayed on");
    retrigger_a: assert property (hit[1] && timed && !manual_rst |=> on[1] && otmr[1] == $past(dur[1]))
        else $error("retrigger did not reload");
    err_clear_a: assert property (enter_press && running_state |=> !err)
        else $error("error flag not cleared");

endmodule : preset_timer

/* File: verification/panel_model.sv */
// Operator panel and rear switch bank that face the preset timer.
// Assumes one clock; every contact changes just after a rising edge.
`timescale 1ns/1ps
module panel_model
    import timer_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Rear switches
    output logic [3:0] mode_sw,
    output logic res_sw,
    output logic unit_sw,
    output logic dis_sw,
    // Active-low contacts
    output ctl_in_t ctl
);
    // ==================================================================
    // Contacts
    // ==================================================================
    // All contacts open at power-up, so pull-ups read high
    initial begin
        mode_sw = 4'h0;
        res_sw = 1'b0;
        unit_sw = 1'b0;
        dis_sw = 1'b0;
        ctl = '1;
    end
    // Contact held for a while, so it outlasts the debounce window
    task automatic drive(input int i, input logic v, input int hold);
        @(posedge clk_sys);
        ctl[i] <= v;
        repeat (hold) @(posedge clk_sys);
    endtask : drive
    // Switch bank moved as one, then left to settle
    task automatic set_sw(input logic [3:0] m, input logic r, input logic d, input logic u);
        @(posedge clk_sys);
        mode_sw <= m;
        unit_sw <= u;
        res_sw <= r;
        dis_sw <= d;
        repeat (12) @(posedge clk_sys);
    endtask : set_sw
endmodule : panel_model

/* File: verification/dual_preset_timer_control_tb_top.sv */
// Self-checking bench for the preset timer: register port, counting, resets.
// Assumes the store starts blank and short tick and debounce parameters.
`timescale 1ns/1ps
module dual_preset_timer_control_tb_top;
    import timer_pkg::*;
    localparam int MSC = 20;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [3:0] mode_sw;
    logic res_sw;
    logic unit_sw;
    logic dis_sw;
    ctl_in_t ctl;
    logic [1:0] ss_out;
    logic [1:0] relay_out;
    logic [1:0] display_decimals;
    logic [COUNT_W-1:0] time_value;
    logic data_error;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int p2 = 0;
    bit lock_on = 1'b0;
    int mreg [int];
    logic [31:0] lfsr = 32'h6AB7B9EB;
    // ==================================================================
    // Design and panel
    // ==================================================================
    panel_model pm (.clk_sys(clk_sys), .mode_sw(mode_sw), .res_sw(res_sw), .unit_sw(unit_sw),
        .dis_sw(dis_sw), .ctl(ctl));
    preset_timer #(.MS_CYCLES(MSC), .DEB_CYCLES(4)) dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .mode_select_switches(mode_sw),
        .resolution_switch(res_sw), .time_unit_switch(unit_sw), .panel_reset_switch(dis_sw),
        .run_in_n(ctl.run), .remote_reset_in_n(ctl.remote_rst), .edit_lock_in_n(ctl.edit_lock),
        .panel_reset_btn_n(ctl.panel_btn), .enter_key_n(ctl.enter), .ss_out(ss_out),
        .relay_out(relay_out), .time_value(time_value), .display_decimals(display_decimals),
        .data_error(data_error));
    // ==================================================================
    // Clock, timeout and helpers
    // ==================================================================
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // Ceiling well above the longest down count at coarse resolution
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            wrap_up();
        end
    end
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check
    // Model follows only what the timer should accept
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ok;
        ok = (a < 8'h08) ? (d <= 32'd999999) : (d >= 1 && d <= 9999);
        if (!lock_on && ok) mreg[a] = d;
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        @(negedge clk_sys);
        check(rdata, mreg.exists(a) ? mreg[a] : 0, "read");
    endtask : rd
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    // ==================================================================
    // Main sequence
    // ==================================================================
    initial begin
        for (int a = 0; a < 16; a += 4) mreg[a] = 0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check(data_error, 1'b1, "blank store flag");
        pm.drive(4, 1'b0, 12);
        pm.drive(4, 1'b1, 12);
        check(data_error, 1'b0, "flag after enter");
        $display("test 1 done");
        // Random first preset, second one above it
        lfsr = next_rand(lfsr);
        p2 = int'(lfsr[2:0]) + 8;
        wr(8'h00, {29'h0, lfsr[2:0]} + 32'h3);
        wr(8'h04, p2);
        wr(8'h08, 32'h000A);
        wr(8'h0C, 32'h0000);
        wr(8'h0C, 32'h2710);
        wr(8'h0C, 32'h270F);
        for (int a = 0; a < 16; a += 4) rd(a[7:0]);
        rd(8'h20);
        pm.drive(2, 1'b0, 12);
        lock_on = 1'b1;
        wr(8'h00, 32'h7);
        rd(8'h00);
        pm.drive(2, 1'b1, 12);
        lock_on = 1'b0;
        $display("test 2 done");
        // Up count, hold at the second preset
        pm.set_sw(4'h4, 1'b1, 1'b0, 1'b0);
        pm.drive(1, 1'b0, 12);
        pm.drive(1, 1'b1, 12);
        check(time_value, 0, "up reset value");
        pm.drive(0, 1'b0, (p2 + 4) * MSC + 20);
        pm.drive(0, 1'b1, 12);
        check(time_value, p2, "up final count");
        check(ss_out, 2'h3, "up outputs");
        check(relay_out, 2'h3, "relay pair");
        check(display_decimals, 2'h3, "fine decimals");
        pm.set_sw(4'h4, 1'b1, 1'b1, 1'b0);
        pm.drive(3, 1'b0, 12);
        pm.drive(3, 1'b1, 12);
        check(time_value, p2, "disabled panel reset");
        pm.drive(1, 1'b0, 40);
        check(time_value, 0, "remote reset count");
        check(ss_out, 2'h0, "remote reset outputs");
        wr(8'h18, 32'h1);
        repeat (2) @(posedge clk_sys);
        check(ss_out, 2'h3, "output test drive");
        rd(8'h18);
        wr(8'h18, 32'h0);
        pm.drive(0, 1'b0, 3 * MSC);
        check(time_value, 0, "held in reset");
        pm.drive(0, 1'b1, 12);
        pm.drive(1, 1'b1, 12);
        $display("test 3 done");
        // Down count from the second preset at coarse resolution
        pm.set_sw(4'hC, 1'b0, 1'b0, 1'b0);
        pm.drive(3, 1'b0, 12);
        pm.drive(3, 1'b1, 12);
        check(time_value, p2, "down reset value");
        check(display_decimals, 2'h2, "coarse decimals");
        pm.drive(0, 1'b0, (p2 + 2) * MSC * 10);
        pm.drive(0, 1'b1, 12);
        check(time_value, 0, "down final count");
        check(ss_out, 2'h3, "down outputs");
        pm.set_sw(4'hC, 1'b1, 1'b0, 1'b1);
        pm.drive(3, 1'b0, 12);
        pm.drive(3, 1'b1, 12);
        pm.drive(0, 1'b0, 30 * MSC);
        pm.drive(0, 1'b1, 12);
        check(time_value, p2, "minute base holds");
        pm.set_sw(4'hD, 1'b1, 1'b0, 1'b0);
        pm.drive(3, 1'b0, 12);
        pm.drive(3, 1'b1, 12);
        pm.drive(0, 1'b0, (p2 + 4) * MSC);
        pm.drive(0, 1'b1, 12);
        check(ss_out, 2'h3, "timed outputs on");
        repeat (2400) @(posedge clk_sys);
        check(ss_out, 2'h2, "timed output 1 off");
        $display("test 4 done");
        // Settings outlive a reset
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        for (int a = 0; a < 16; a += 4) rd(a[7:0]);
        check(data_error, 1'b0, "valid store flag");
        $display("test 5 done");
        wrap_up();
    end
endmodule : dual_preset_timer_control_tb_top
